// *** shared/ssbg_pkg.sv ***
// Shared constants and types for the serial service and baud generator block.
// Assumes a 32-bit APB register bus and one system clock.
package ssbg_pkg;

    // ****************************************************************
    // Register byte offsets.
    // ****************************************************************
    localparam logic [7:0] OFS_STAT0 = 8'h00;
    localparam logic [7:0] OFS_IEN0 = 8'h04;
    localparam logic [7:0] OFS_SRC = 8'h08;
    localparam logic [7:0] OFS_SRCEN = 8'h0c;
    localparam logic [7:0] OFS_TMC = 8'h10;
    localparam logic [7:0] OFS_TXSEL = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int ST0_RX_READY_FLAG = 0;
    localparam int ST0_TX_READY_FLAG = 1;
    localparam int ST0_RXSUM = 2;
    localparam int ST0_TXSUM = 3;
    localparam int IEN_W = 4;
    localparam int SRC_CDC = 0;
    localparam int SRC_PMP = 3;
    localparam int SRC_OVR = 6;
    localparam int RX_SRC_N = 7;
    localparam int SRC_CTS = 7;
    localparam int SRC_IDL = 8;
    localparam int SRC_N = 9;
    localparam int CMD_CHAN = 0;
    localparam int CMD_RX = 1;
    localparam int CMD_TX = 2;

    // ****************************************************************
    // Widths and reset values.
    // ****************************************************************
    localparam int TMC_W = 8;
    localparam int DIV_W = 4;
    localparam int CNT_W = 9;
    localparam int DIVCNT_W = 9;
    localparam logic [3:0] DIV_MAX = 4'h9;
    localparam logic [IEN_W-1:0] IEN_RST = 4'h0;
    localparam logic [SRC_N-1:0] SRCEN_RST = 9'h000;
    localparam logic [7:0] TMC_RST = 8'h00;
    localparam logic [3:0] DIV_RST = 4'h0;

    // ****************************************************************
    // Grouped signals.
    // ****************************************************************
    typedef struct packed {
        logic overrun;
        logic frame_err;
        logic parity_err;
        logic mpbit;
        logic brk_end;
        logic brk_start;
        logic carrier_chg;
    } ssbg_rx_evt_t;

    typedef struct packed {
        logic tx_summary;
        logic rx_summary;
        logic tx_ready;
        logic rx_ready;
    } ssbg_irq_t;

endpackage

// *** core/ssbg_flag.sv ***
// Sticky status bit: hardware sets, any clear source clears, set wins.
// Assumes set and clear come from logic on pclk.
`timescale 1ns/10ps
`default_nettype none

module ssbg_flag
(
    input wire logic pclk,    // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic set,     // Set pulse.
    input wire logic clr,     // Clear pulse.
    output logic q            // Flag value.
);

    logic q_r;
    logic q_nxt;

    assign q_nxt = set | (q_r & ~clr);
    assign q = q_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q_r <= 1'b0;
        else
            q_r <= q_nxt;
    end

endmodule
`default_nettype wire

// *** core/ssbg_baud.sv ***
// Baud generator: reload down-counter followed by a power-of-two divider.
// Assumes the time constant and divider field come from registers on pclk.
`timescale 1ns/10ps
`default_nettype none

module ssbg_baud
    import ssbg_pkg::*;
#(
    parameter int TW = TMC_W,
    parameter int DW = DIV_W
)
(
    input wire logic pclk,          // System clock.
    input wire logic presetn,       // Asynchronous reset, active low.
    input wire logic [TW-1:0] baud_time_constant,  // Time constant.
    input wire logic [DW-1:0] div,  // Divider field.
    output logic tout,              // Reload timer output.
    output logic brg_out            // Baud generator output.
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] load_val;
    logic [DIVCNT_W-1:0] dcnt_r;
    logic [DW-1:0] div_q;
    logic brg_r;
    logic brg_nxt;

    // ****************************************************************
    // Reload timer.
    // ****************************************************************
    assign load_val = (baud_time_constant == '0) ? 9'h100 : {1'b0, baud_time_constant};              // see R16
    assign tout = (cnt_r == 9'h001);                                     // see R15
    assign cnt_nxt = (cnt_r <= 9'h001) ? load_val : cnt_r - 9'h001;    // see R21

    // ****************************************************************
    // Divider: bit n-1 of a pulse counter is a 50% square at 1/2^n.
    // ****************************************************************
    assign div_q = (div > DIV_MAX) ? DIV_MAX : div;
    assign brg_nxt = (div_q == '0) ? tout : dcnt_r[div_q - 4'h1];     // see R17, R18, R14
    assign brg_out = brg_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 9'h000;
            dcnt_r <= 9'h000;
            brg_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            dcnt_r <= dcnt_r + {8'h00, tout};
            brg_r <= brg_nxt;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_pulse_one_wide: assert property (@(posedge pclk) disable iff (!presetn) // see R15
        tout && baud_time_constant != 8'h01 |=> !tout)
        else $error("Reload timer pulse wider than one cycle.");

    a_reload_after_one: assert property (@(posedge pclk) disable iff (!presetn) // see R21
        tout |=> cnt_r == $past(load_val))
        else $error("Reload timer did not reload the time constant.");

    a_zero_is_256: assert property (@(posedge pclk) disable iff (!presetn) // see R16
        tout && baud_time_constant == 8'h00 |=> cnt_r == 9'h100 ##255 tout)
        else $error("Time constant zero does not count 256.");

    a_div_zero_pass: assert property (@(posedge pclk) disable iff (!presetn) // see R17
        div == 4'h0 |=> brg_out == $past(tout))
        else $error("Timer output not passed through with divider zero.");

    a_div_square_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R18
        !tout ##1 (div_q != 4'h0 && $stable(div_q)) |=> $stable(brg_out))
        else $error("Divided output toggled without a timer pulse.");

endmodule
`default_nettype wire

// *** core/ssbg_top.sv ***
// Serial channel service logic: ready flags, DMA requests, interrupt
// summaries with write-one-to-clear sources except transmitter idle, and the baud generator.
// Assumes an APB master on pclk and channel logic on pclk driving the events.
//
// Overview of operation
// R1: Ready flag set raises DMA transfer request.
// R2: Software disables ready interrupts under DMA.
// R3: DMA dual-address cycle-steal; request is level.
// R4: Polling reads ready flags, interrupts and DMA off.
// R5: Interrupt mode: DMA ignores channel requests.
// R6: Ready interrupt is flag AND its enable.
// R7: Ready flags clear on empty, full, disabled.
// R8: Receive summary ORs seven gated sources.
// R9: Transmit summary ORs idle and CTS change.
// R10: Writing one clears source status bits; the code clears bits 0 to 7 only, not idle bit 8.
// R11: Reset commands clear ready and summary interrupts.
// R12: Parity/MP bit clears on next ready set.
// R13: Summary status ignores summary interrupt enables.
// R14: Baud output spans half clock to 2^17.
// R15: Reload timer pulses one cycle at count one.
// R16: Constant zero counts 256; one holds high.
// R17: Divider field zero passes timer output.
// R18: Fields one to nine give 50% square.
// R19: Software never sets baud equal to clock.
// R20: Break start and end set status bits.
// R21: After pulse, timer reloads and keeps counting.
`timescale 1ns/10ps
`default_nettype none

module ssbg_top
    import ssbg_pkg::*;
(
    input wire logic pclk,                // System clock, 40 MHz.
    input wire logic presetn,             // Asynchronous reset, active low.
    input wire logic psel,                // APB select.
    input wire logic penable,             // APB enable.
    input wire logic pwrite,              // APB write.
    input wire logic [7:0] paddr,         // APB byte address.
    input wire logic [31:0] pwdata,       // APB write data.
    output logic [31:0] prdata,           // APB read data.
    output logic pready,                  // APB ready.
    output logic pslverr,                 // APB error on unmapped address.
    input wire logic rx_char_load,        // Character loaded into receive buffer.
    input wire logic rx_buf_empty,        // Receive buffer empty.
    input wire logic tx_space_evt,        // Transmit buffer gained room.
    input wire logic tx_buf_full,         // Transmit buffer full.
    input wire logic tx_enabled,          // Transmitter enabled.
    input wire logic tx_idle,             // Transmitter in idle state.
    input wire ssbg_rx_evt_t rx_evt,      // Receive source event pulses.
    input wire logic cts_chg_evt,         // Clear-to-send change pulse.
    output logic dma_rx_req,              // Receive DMA request, level.
    output logic dma_tx_req,              // Transmit DMA request, level.
    output ssbg_irq_t irq,                // Interrupt lines.
    output logic baud_out                 // Baud generator output.
);

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire logic setup_ph;
    wire logic access_ph;
    wire logic wr_en;
    wire logic sel_st0;
    wire logic sel_ien;
    wire logic sel_src;
    wire logic sel_srcen;
    wire logic sel_tmc;
    wire logic sel_txsel;
    wire logic sel_cmd;
    wire logic addr_hit;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en = access_ph & pwrite;
    assign sel_st0 = (paddr == OFS_STAT0);
    assign sel_ien = (paddr == OFS_IEN0);
    assign sel_src = (paddr == OFS_SRC);
    assign sel_srcen = (paddr == OFS_SRCEN);
    assign sel_tmc = (paddr == OFS_TMC);
    assign sel_txsel = (paddr == OFS_TXSEL);
    assign sel_cmd = (paddr == OFS_CMD);
    assign addr_hit = sel_st0 | sel_ien | sel_src | sel_srcen | sel_tmc | sel_txsel | sel_cmd;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~addr_hit;

    // ****************************************************************
    // Software registers and commands.
    // ****************************************************************
    logic [IEN_W-1:0] ien_r;
    logic [SRC_N-1:0] srcen_r;
    logic [TMC_W-1:0] tmc_r;
    logic [DIV_W-1:0] div_r;
    wire logic chan_rst;
    wire logic rx_rst;
    wire logic tx_rst;

    assign chan_rst = wr_en & sel_cmd & pwdata[CMD_CHAN];
    assign rx_rst = chan_rst | (wr_en & sel_cmd & pwdata[CMD_RX]);
    assign tx_rst = chan_rst | (wr_en & sel_cmd & pwdata[CMD_TX]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ien_r <= IEN_RST;
            srcen_r <= SRCEN_RST;
            tmc_r <= TMC_RST;
            div_r <= DIV_RST;
        end
        else if (wr_en)
        begin
            if (sel_ien)
                ien_r <= pwdata[IEN_W-1:0];
            if (sel_srcen)
                srcen_r <= pwdata[SRC_N-1:0];
            if (sel_tmc)
                tmc_r <= pwdata[TMC_W-1:0];
            if (sel_txsel)
                div_r <= pwdata[DIV_W-1:0];
        end
    end

    // ****************************************************************
    // Ready flags.
    // ****************************************************************
    logic rx_ready_r;
    logic rx_ready_nxt;
    logic tx_ready_r;
    logic tx_ready_nxt;
    wire logic tx_can_take;

    // A new character wins over the empty indication and the reset command.
    assign rx_ready_nxt = rx_char_load | (rx_ready_r & ~rx_buf_empty & ~rx_rst);     // see R7, R11
    assign tx_can_take = ~tx_buf_full & tx_enabled;
    assign tx_ready_nxt = tx_can_take & (tx_space_evt | (tx_ready_r & ~tx_rst));      // see R7, R11

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ready_r <= 1'b0;
            tx_ready_r <= 1'b0;
        end
        else
        begin
            rx_ready_r <= rx_ready_nxt;
            tx_ready_r <= tx_ready_nxt;
        end
    end

    // The request is a level that stays up while the flag is set.
    assign dma_rx_req = rx_ready_r;                                                    // see R1, R3
    assign dma_tx_req = tx_ready_r;                                                    // see R1, R3

    // ****************************************************************
    // Interrupt source bits.
    // ****************************************************************
    wire logic [SRC_CTS:0] src_set;
    logic [SRC_CTS:0] src_clr;
    wire logic [SRC_CTS:0] src_q;
    wire logic [SRC_CTS:0] src_w1c;
    wire logic pmp_auto_clr;

    // Break start and end arrive as their own event bits.
    assign src_set = {cts_chg_evt, rx_evt};                                            // see R20
    assign src_w1c = (wr_en & sel_src) ? pwdata[SRC_CTS:0] : 8'h00;                   // see R10
    assign pmp_auto_clr = rx_char_load & ~rx_ready_r;                                  // see R12

    always_comb
    begin
        src_clr = src_w1c;
        src_clr[RX_SRC_N-1:0] = src_w1c[RX_SRC_N-1:0] | {RX_SRC_N{rx_rst}};          // see R11
        src_clr[SRC_CTS] = src_w1c[SRC_CTS] | tx_rst;                                  // see R11
        src_clr[SRC_PMP] = src_clr[SRC_PMP] | pmp_auto_clr;                            // see R12
    end

    genvar gi;
    generate
        for (gi = 0; gi <= SRC_CTS; gi++)
        begin : g_src
            ssbg_flag u_flag
            (
                .pclk(pclk),
                .presetn(presetn),
                .set(src_set[gi]),
                .clr(src_clr[gi]),
                .q(src_q[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Transmitter idle status.
    // ****************************************************************
    logic idle_d_r;
    logic quiet_r;
    logic quiet_nxt;

    assign quiet_nxt = tx_idle & ((tx_idle & ~idle_d_r) | (quiet_r & ~tx_rst));       // see R9

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_d_r <= 1'b0;
            quiet_r <= 1'b0;
        end
        else
        begin
            idle_d_r <= tx_idle;
            quiet_r <= quiet_nxt;
        end
    end

    // ****************************************************************
    // Summaries and interrupt lines.
    // ****************************************************************
    wire logic rx_sum;
    wire logic tx_sum;
    ssbg_irq_t irq_r;
    ssbg_irq_t irq_nxt;

    assign rx_sum = |(src_q[RX_SRC_N-1:0] & srcen_r[RX_SRC_N-1:0]);                  // see R8
    assign tx_sum = (quiet_r & srcen_r[SRC_IDL]) | (src_q[SRC_CTS] & srcen_r[SRC_CTS]); // see R9
    assign irq_nxt.rx_ready = rx_ready_r & ien_r[ST0_RX_READY_FLAG];                           // see R6
    assign irq_nxt.tx_ready = tx_ready_r & ien_r[ST0_TX_READY_FLAG];                           // see R6
    assign irq_nxt.rx_summary = rx_sum & ien_r[ST0_RXSUM];                             // see R8
    assign irq_nxt.tx_summary = tx_sum & ien_r[ST0_TXSUM];                             // see R9
    assign irq = irq_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= '0;
        else
            irq_r <= irq_nxt;
    end

    // ****************************************************************
    // Read data, captured in the setup phase.
    // ****************************************************************
    logic [31:0] rd_word;
    logic [31:0] prdata_r;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (sel_st0)
        begin
            rd_word[ST0_RX_READY_FLAG] = rx_ready_r;
            rd_word[ST0_TX_READY_FLAG] = tx_ready_r;
            rd_word[ST0_RXSUM] = rx_sum;                                               // see R13
            rd_word[ST0_TXSUM] = tx_sum;                                               // see R13
        end
        else if (sel_ien)
            rd_word[IEN_W-1:0] = ien_r;
        else if (sel_src)
        begin
            rd_word[SRC_CTS:0] = src_q;
            rd_word[SRC_IDL] = quiet_r;
        end
        else if (sel_srcen)
            rd_word[SRC_N-1:0] = srcen_r;
        else if (sel_tmc)
            rd_word[TMC_W-1:0] = tmc_r;
        else if (sel_txsel)
            rd_word[DIV_W-1:0] = div_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup_ph)
            prdata_r <= rd_word;
    end

    assign prdata = prdata_r;

    // ****************************************************************
    // Baud generator.
    // ****************************************************************
    ssbg_baud #(
        .TW(TMC_W),
        .DW(DIV_W)
    ) u_baud
    (
        .pclk(pclk),
        .presetn(presetn),
        .baud_time_constant(tmc_r),
        .div(div_r),
        .tout(),
        .brg_out(baud_out)
    );

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_dma_follows_load: assert property (@(posedge pclk) disable iff (!presetn) // see R1
        rx_char_load |=> dma_rx_req)
        else $error("Receive DMA request missing after character load.");

    a_rx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        rx_ready_r && ien_r[ST0_RX_READY_FLAG] |=> irq.rx_ready)
        else $error("Receive ready interrupt not raised.");

    a_rx_flag_empty: assert property (@(posedge pclk) disable iff (!presetn) // see R7
        rx_buf_empty && !rx_char_load |=> !rx_ready_r)
        else $error("Receive ready flag not cleared on empty buffer.");

    a_tx_flag_full: assert property (@(posedge pclk) disable iff (!presetn) // see R7
        (tx_buf_full || !tx_enabled) |=> !tx_ready_r && !dma_tx_req)
        else $error("Transmit ready flag not cleared on full or disabled.");

    a_rx_sum_overrun: assert property (@(posedge pclk) disable iff (!presetn) // see R8
        rx_evt.overrun && srcen_r[SRC_OVR] && !(wr_en && sel_srcen) |=> rx_sum ##1 irq.rx_summary == ien_r[ST0_RXSUM])
        else $error("Overrun did not reach the receive summary.");

    a_idle_leave: assert property (@(posedge pclk) disable iff (!presetn) // see R9
        $fell(tx_idle) |=> !quiet_r)
        else $error("Idle status survived leaving idle.");

    a_w1c_carrier: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        wr_en && sel_src && pwdata[SRC_CDC] && !rx_evt.carrier_chg |=> !src_q[SRC_CDC])
        else $error("Write of one did not clear carrier change status.");

    a_rx_reset_cmd: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        rx_rst && !rx_char_load && rx_evt == '0 |=> !rx_ready_r && !rx_sum)
        else $error("Receive reset left ready or summary set.");

    a_pmp_next_char: assert property (@(posedge pclk) disable iff (!presetn) // see R12
        rx_char_load && !rx_ready_r && !rx_evt.mpbit |=> !src_q[SRC_PMP])
        else $error("Parity or MP status not cleared by next character.");

    a_st0_summary: assert property (@(posedge pclk) disable iff (!presetn) // see R13
        setup_ph && sel_st0 && tx_sum && !ien_r[ST0_TXSUM] |=> prdata[ST0_TXSUM])
        else $error("Transmit summary hidden by its enable.");

endmodule
`default_nettype wire

// *** testbench/ssbg_dma_model.sv ***
// DMA controller model that serves receive requests by emptying the buffer.
// Assumes the bench pulses rx_char_load whenever a character arrives.
`timescale 1ns/10ps
`default_nettype none

module ssbg_dma_model
(
    input wire logic pclk,          // System clock.
    input wire logic presetn,       // Reset, active low.
    input wire logic dma_on,        // Controller answers the channel.
    input wire logic dma_rx_req,    // Receive request level.
    input wire logic rx_char_load,  // Character arrived.
    output logic rx_buf_empty       // Receive buffer empty.
);
    logic [1:0] wait_r;

    // The request is sensed by level; the buffer empties on the second cycle the request is seen.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r <= 2'h0;
            rx_buf_empty <= 1'b1;
        end
        else if (rx_char_load)
        begin
            wait_r <= 2'h0;
            rx_buf_empty <= 1'b0;
        end
        else if (dma_on && dma_rx_req && !rx_buf_empty)
        begin
            wait_r <= wait_r + 2'h1;
            if (wait_r == 2'h1)
                rx_buf_empty <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** testbench/serial_service_and_baud_gen_tb.sv ***
// Self-checking bench for the serial service and baud generator block.
// Assumes the design package and a DMA model on the receive side.
`timescale 1ns/10ps
`default_nettype none

module serial_service_and_baud_gen_tb
    import ssbg_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, cnt;
    logic pready, pslverr, last_err, rx_buf_empty, dma_rx_req, dma_tx_req, baud_out;
    logic rx_char_load = 0, tx_space_evt = 0, tx_buf_full = 0, tx_enabled = 0;
    logic tx_idle = 0, cts_chg_evt = 0, dma_on = 0;
    ssbg_rx_evt_t rx_evt = '0;
    ssbg_irq_t irq;
    int failures = 0, comparisons = 0;
    // No pair gives a baud output at the full system clock (time constant 1 with divider 0).
    int tcs[6] = '{3, 0, 2, 3, 1, 1};
    int dvs[6] = '{0, 0, 0, 2, 1, 9};
    int win[6] = '{30, 512, 40, 48, 40, 1024};
    int hi[6] = '{10, 2, 20, 24, 20, 512};

    ssbg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_char_load(rx_char_load), .rx_buf_empty(rx_buf_empty),
        .tx_space_evt(tx_space_evt), .tx_buf_full(tx_buf_full), .tx_enabled(tx_enabled),
        .tx_idle(tx_idle), .rx_evt(rx_evt), .cts_chg_evt(cts_chg_evt), .dma_rx_req(dma_rx_req),
        .dma_tx_req(dma_tx_req), .irq(irq), .baud_out(baud_out));

    ssbg_dma_model u_dma (.pclk(pclk), .presetn(presetn), .dma_on(dma_on),
        .dma_rx_req(dma_rx_req), .rx_char_load(rx_char_load), .rx_buf_empty(rx_buf_empty));

    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ends two edges after the access so registered interrupts have settled.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    // Bit 9 load, bit 8 transmit room, bit 7 clear-to-send, bits 6..0 receive sources.
    task automatic ev(input logic [9:0] v);
        {rx_char_load, tx_space_evt, cts_chg_evt, rx_evt} <= v;
        @(posedge pclk);
        {rx_char_load, tx_space_evt, cts_chg_evt, rx_evt} <= 10'h0;
        @(posedge pclk);
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        failures++;
        stop_test;
    end

    // ****************************************************************
    // Tests.
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_IEN0, 32'h0);
        rd(OFS_SRCEN, 32'h0);
        rd(OFS_TMC, 32'h0);
        rd(OFS_TXSEL, 32'h0);
        rd(8'h1c, 32'h0);
        chk(last_err, 1'b1);
        wr(OFS_TMC, 32'h5a);
        rd(OFS_TMC, 32'h5a);
        ev(10'h200);
        chk(dma_rx_req, 1'b1);
        rd(OFS_STAT0, 32'h1);
        chk(irq, 4'h0);
        wr(OFS_IEN0, 32'h1);
        chk(irq, 4'h1);
        wr(OFS_CMD, 32'h1 << CMD_RX);
        rd(OFS_STAT0, 32'h0);
        chk(irq, 4'h0);
        wr(OFS_IEN0, 32'h0);
        dma_on <= 1'b1;
        ev(10'h200);
        repeat (6) @(posedge pclk);
        chk(rx_buf_empty, 1'b1);
        rd(OFS_STAT0, 32'h0);
        ev(10'h1);
        rd(OFS_STAT0, 32'h0);
        wr(OFS_SRC, 32'h1);
        wr(OFS_SRCEN, 32'h1ff);
        for (int i = 0; i < 8; i++)
        begin
            ev(10'h1 << i);
            rd(OFS_SRC, 32'h1 << i);
            rd(OFS_STAT0, (i < 7) ? 32'h4 : 32'h8);
            wr(OFS_IEN0, 32'hc);
            chk(irq, (i < 7) ? 4'h4 : 4'h8);
            wr(OFS_SRC, 32'h0);
            rd(OFS_SRC, 32'h1 << i);
            wr(OFS_SRC, 32'h1 << i);
            wr(OFS_IEN0, 32'h0);
            rd(OFS_SRC, 32'h0);
        end
        ev(10'h8);
        rd(OFS_SRC, 32'h8);
        ev(10'h200);
        rd(OFS_SRC, 32'h0);
        tx_enabled <= 1'b1;
        ev(10'h100);
        chk(dma_tx_req, 1'b1);
        tx_buf_full <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(OFS_STAT0, 32'h0);
        tx_buf_full <= 1'b0;
        ev(10'h100);
        tx_enabled <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(OFS_STAT0, 32'h0);
        tx_enabled <= 1'b1;
        tx_idle <= 1'b1;
        ev(10'h100);
        rd(OFS_SRC, 32'h100);
        tx_idle <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(OFS_SRC, 32'h0);
        tx_idle <= 1'b1;
        wr(OFS_IEN0, 32'ha);
        chk(irq, 4'ha);
        wr(OFS_CMD, 32'h1 << CMD_TX);
        rd(OFS_STAT0, 32'h0);
        chk(irq, 4'h0);
        dma_on <= 1'b0;
        ev(10'h300);
        rd(OFS_STAT0, 32'h3);
        wr(OFS_CMD, 32'h1 << CMD_CHAN);
        rd(OFS_STAT0, 32'h0);
        for (int k = 0; k < 6; k++)
        begin
            wr(OFS_TMC, tcs[k]);
            wr(OFS_TXSEL, dvs[k]);
            repeat (300 + win[k]) @(posedge pclk);
            cnt = 32'h0;
            repeat (win[k])
            begin
                @(posedge pclk);
                cnt = cnt + 32'(baud_out);
            end
            chk(cnt, hi[k]);
        end
        stop_test;
    end
endmodule
`default_nettype wire
